// *** flash_seq_pkg.sv ***
// Constants, types and carriers shared by the flash program and erase sequencer.
// Assumes a single 20 MHz system clock and an active-low asynchronous reset.
package flash_seq_pkg;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int ADDR_HIGH_W = 8;
    localparam int ADDR_LOW_W = 16;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int ROW_WORDS_DEF = 64;
    localparam int CTRL_START_BIT = 15;
    localparam int CTRL_OP_LSB = 0;
    localparam logic [15:0] RAM_STEP = 16'h0002;
    localparam logic [7:0] ADDR_HIGH_RST = 8'h00;
    localparam logic [15:0] ADDR_LOW_RST = 16'h0000;
    localparam logic [15:0] SRC_RST = 16'h0000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0] {
        OP_PAGE_ERASE = 2'h0,
        OP_WORD_PROG = 2'h1,
        OP_ROW_PROG = 2'h2,
        OP_INACT_ERASE = 2'h3
    } flash_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_FETCH = 3'h1,
        ST_LOAD = 3'h3,
        ST_ISSUE = 3'h2,
        ST_WAIT = 3'h6
    } seq_state_t;

    typedef enum logic [1:0] {
        UNL_NONE = 2'h0,
        UNL_HALF = 2'h1,
        UNL_ARMED = 2'h3
    } unlock_state_t;

    typedef struct packed {
        flash_op_t op;
        logic [ADDR_W-1:0] addr;
    } flash_cmd_t;

endpackage : flash_seq_pkg

// *** flash_unlock_seq.sv ***
// Unlock key detector for the flash sequencer.
// Assumes at most one register write strobe is active in any cycle.
`timescale 1ns/1ps
module flash_unlock_seq (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic key_we, // Write strobe of the unlock key.
    input wire logic [7:0] key_data, // Data written to the unlock key.
    input wire logic other_we, // Any other register write, start included.
    output logic unlocked // High while the key pair has just been written.
);

    flash_seq_pkg::unlock_state_t unl_r;
    flash_seq_pkg::unlock_state_t unl_nxt;

    // =========================================================
    // Key sequence
    // The key is write-only: nothing here can be read back.
    always_comb begin
        unl_nxt = unl_r;
        if (key_we) begin
            if (key_data == flash_seq_pkg::KEY_FIRST) begin
                unl_nxt = flash_seq_pkg::UNL_HALF;
            end else if (key_data == flash_seq_pkg::KEY_SECOND &&
                         unl_r == flash_seq_pkg::UNL_HALF) begin
                unl_nxt = flash_seq_pkg::UNL_ARMED;
            end else begin
                unl_nxt = flash_seq_pkg::UNL_NONE;
            end
        end else if (other_we) begin
            unl_nxt = flash_seq_pkg::UNL_NONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unl_r <= flash_seq_pkg::UNL_NONE;
        end else begin
            unl_r <= unl_nxt;
        end
    end

    assign unlocked = (unl_r == flash_seq_pkg::UNL_ARMED);

    a_key_pair: assert property (@(posedge clk) disable iff (!rst_n)
        key_we && key_data == flash_seq_pkg::KEY_FIRST ##1
        key_we && key_data == flash_seq_pkg::KEY_SECOND |=> unlocked)
        else $error("Key pair did not unlock.");

    a_other_cancels: assert property (@(posedge clk) disable iff (!rst_n)
        other_we && !key_we |=> !unlocked)
        else $error("Unlock survived another write.");

endmodule : flash_unlock_seq

// *** flash_seq_ctrl.sv ***
// Flash program and erase sequencer: holds the control, address and source
// pointer registers, checks the unlock, fetches row data and drives the array.
// Assumes the array answers FL_DONE for one cycle some time after FL_REQ, and
// that RAM returns read data in the cycle after RAM_RD.
`timescale 1ns/1ps
module flash_seq_ctrl #(
    parameter int ROW_WORDS = flash_seq_pkg::ROW_WORDS_DEF
) (
    input wire logic MCLK, // System clock, 20 MHz.
    input wire logic RESETN, // Asynchronous reset, active low.
    input wire logic [15:0] WDATA, // Register write data.
    input wire logic KEY_WE, // Write strobe, unlock key.
    input wire logic CTRL_WE, // Write strobe, operation control.
    input wire logic ADDR_HIGH_WE, // Write strobe, high address.
    input wire logic ADDR_LOW_WE, // Write strobe, low address.
    input wire logic SRC_WE, // Write strobe, row source pointer.
    input wire logic OTHER_WE, // Write to any unrelated register.
    input wire logic ACTIVE_PART_IN, // Active partition strap.
    input wire logic [15:0] RAM_RDATA, // RAM read data, one cycle after RAM_RD.
    input wire logic FL_DONE, // Array finished the cycle.
    output flash_seq_pkg::flash_op_t OP_SEL, // Selected operation.
    output logic BUSY, // Cycle in progress.
    output logic ACTIVE_PART, // Active partition.
    output logic START_REFUSED, // One-cycle pulse on a refused start.
    output logic [15:0] RAM_ADDR, // RAM read address.
    output logic RAM_RD, // RAM read strobe.
    output logic FL_WSTB, // Row data word strobe to the array.
    output logic [15:0] FL_WDATA, // Row data word.
    output flash_seq_pkg::flash_cmd_t FL_CMD, // Operation and target address.
    output logic FL_REQ // One-cycle start pulse to the array.
);

    localparam int IDX_W = (ROW_WORDS > 1) ? $clog2(ROW_WORDS) : 1;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(ROW_WORDS - 1);

    logic unlocked;
    logic start_req;
    logic start_ok;
    logic any_we;

    // =========================================================
    // Unlock
    assign any_we = CTRL_WE | ADDR_HIGH_WE | ADDR_LOW_WE | SRC_WE | OTHER_WE;
    assign start_req = CTRL_WE && WDATA[flash_seq_pkg::CTRL_START_BIT];
    assign start_ok = start_req && unlocked && !BUSY;

    flash_unlock_seq u_unlock (
        .clk(MCLK),
        .rst_n(RESETN),
        .key_we(KEY_WE),
        .key_data(WDATA[7:0]),
        .other_we(any_we),
        .unlocked(unlocked)
    );

    // =========================================================
    // Registers
    logic [7:0] addr_high_r;
    logic [7:0] addr_high_nxt;
    logic [15:0] addr_low_r;
    logic [15:0] addr_low_nxt;
    logic [15:0] src_r;
    logic [15:0] src_nxt;
    flash_seq_pkg::flash_op_t op_r;
    flash_seq_pkg::flash_op_t op_nxt;
    logic part_r;
    logic part_nxt;
    logic part_taken_r;
    logic part_taken_nxt;

    // Registers are frozen while a cycle runs so the array sees a stable target.
    always_comb begin
        addr_high_nxt = addr_high_r;
        addr_low_nxt = addr_low_r;
        src_nxt = src_r;
        op_nxt = op_r;
        part_nxt = part_r;
        part_taken_nxt = 1'b1;
        if (!BUSY && ADDR_HIGH_WE) begin
            addr_high_nxt = WDATA[7:0];
        end
        if (!BUSY && ADDR_LOW_WE) begin
            addr_low_nxt = WDATA;
        end
        if (!BUSY && SRC_WE) begin
            src_nxt = WDATA;
        end
        if (!BUSY && CTRL_WE) begin
            op_nxt = flash_seq_pkg::flash_op_t'(WDATA[flash_seq_pkg::CTRL_OP_LSB +: 2]);
        end
        if (!part_taken_r) begin
            part_nxt = ACTIVE_PART_IN;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_high_r <= flash_seq_pkg::ADDR_HIGH_RST;
            addr_low_r <= flash_seq_pkg::ADDR_LOW_RST;
            src_r <= flash_seq_pkg::SRC_RST;
            op_r <= flash_seq_pkg::OP_PAGE_ERASE;
            part_r <= 1'b0;
            part_taken_r <= 1'b0;
        end else begin
            addr_high_r <= addr_high_nxt;
            addr_low_r <= addr_low_nxt;
            src_r <= src_nxt;
            op_r <= op_nxt;
            part_r <= part_nxt;
            part_taken_r <= part_taken_nxt;
        end
    end

    assign OP_SEL = op_r;
    assign ACTIVE_PART = part_r;

    // =========================================================
    // Sequencer
    flash_seq_pkg::seq_state_t st_r;
    flash_seq_pkg::seq_state_t st_nxt;
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;
    logic busy_nxt;
    logic refused_nxt;
    logic ram_rd_nxt;
    logic [15:0] ram_addr_nxt;
    logic wstb_nxt;
    logic [15:0] wdata_nxt;
    logic req_nxt;
    flash_seq_pkg::flash_cmd_t cmd_nxt;

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        busy_nxt = BUSY;
        refused_nxt = start_req && !start_ok;
        ram_rd_nxt = 1'b0;
        ram_addr_nxt = RAM_ADDR;
        wstb_nxt = 1'b0;
        wdata_nxt = FL_WDATA;
        req_nxt = 1'b0;
        cmd_nxt = FL_CMD;
        unique case (st_r)
            flash_seq_pkg::ST_IDLE: begin
                if (start_ok) begin
                    busy_nxt = 1'b1;
                    cmd_nxt.op = op_nxt;
                    cmd_nxt.addr = {addr_high_r, addr_low_r};
                    idx_nxt = '0;
                    if (op_nxt == flash_seq_pkg::OP_ROW_PROG) begin
                        st_nxt = flash_seq_pkg::ST_FETCH;
                        ram_rd_nxt = 1'b1;
                        ram_addr_nxt = src_r;
                    end else begin
                        st_nxt = flash_seq_pkg::ST_ISSUE;
                    end
                end
            end
            flash_seq_pkg::ST_FETCH: begin
                st_nxt = flash_seq_pkg::ST_LOAD;
            end
            flash_seq_pkg::ST_LOAD: begin
                wstb_nxt = 1'b1;
                wdata_nxt = RAM_RDATA;
                idx_nxt = idx_r + 1'b1;
                if (idx_r == IDX_LAST) begin
                    st_nxt = flash_seq_pkg::ST_ISSUE;
                end else begin
                    st_nxt = flash_seq_pkg::ST_FETCH;
                    ram_rd_nxt = 1'b1;
                    ram_addr_nxt = RAM_ADDR + flash_seq_pkg::RAM_STEP;
                end
            end
            flash_seq_pkg::ST_ISSUE: begin
                req_nxt = 1'b1;
                st_nxt = flash_seq_pkg::ST_WAIT;
            end
            flash_seq_pkg::ST_WAIT: begin
                if (FL_DONE && !FL_REQ) begin
                    busy_nxt = 1'b0;
                    st_nxt = flash_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = flash_seq_pkg::ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= flash_seq_pkg::ST_IDLE;
            idx_r <= '0;
            BUSY <= 1'b0;
            START_REFUSED <= 1'b0;
            RAM_RD <= 1'b0;
            RAM_ADDR <= flash_seq_pkg::SRC_RST;
            FL_WSTB <= 1'b0;
            FL_WDATA <= flash_seq_pkg::DATA_RST;
            FL_REQ <= 1'b0;
            FL_CMD <= '0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            BUSY <= busy_nxt;
            START_REFUSED <= refused_nxt;
            RAM_RD <= ram_rd_nxt;
            RAM_ADDR <= ram_addr_nxt;
            FL_WSTB <= wstb_nxt;
            FL_WDATA <= wdata_nxt;
            FL_REQ <= req_nxt;
            FL_CMD <= cmd_nxt;
        end
    end

    // =========================================================
    // Assertions
    localparam int REQ_MAX = 300;

    a_start_unlocked: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(BUSY) |-> $past(unlocked) && $past(start_req))
        else $error("Cycle started without unlock.");

    a_refused_start: assert property (@(posedge MCLK) disable iff (!RESETN)
        start_req && !unlocked && !BUSY |=> !BUSY && START_REFUSED)
        else $error("Locked start was not refused.");

    a_addr_concat: assert property (@(posedge MCLK) disable iff (!RESETN)
        $rose(BUSY) |-> FL_CMD.addr == {$past(addr_high_r), $past(addr_low_r)})
        else $error("Target address is not the joined registers.");

    a_addr_high: assert property (@(posedge MCLK) disable iff (!RESETN)
        ADDR_HIGH_WE && !BUSY |=> addr_high_r == $past(WDATA[7:0]))
        else $error("High address bits wrong.");

    a_addr_low: assert property (@(posedge MCLK) disable iff (!RESETN)
        ADDR_LOW_WE && !BUSY |=> addr_low_r == $past(WDATA))
        else $error("Low address bits wrong.");

    a_row_source: assert property (@(posedge MCLK) disable iff (!RESETN)
        start_ok && op_nxt == flash_seq_pkg::OP_ROW_PROG |=> RAM_RD && RAM_ADDR == $past(src_r)
        ##1 !RAM_RD ##1 FL_WSTB && FL_WDATA == $past(RAM_RDATA))
        else $error("Row fetch not from source pointer.");

    a_op_select: assert property (@(posedge MCLK) disable iff (!RESETN)
        start_ok |=> FL_CMD.op == $past(op_nxt) && BUSY)
        else $error("Operation not taken from control write.");

    a_start_launch: assert property (@(posedge MCLK) disable iff (!RESETN)
        start_ok |-> ##[2:REQ_MAX] FL_REQ)
        else $error("Start did not reach the array.");

    a_part_stable: assert property (@(posedge MCLK) disable iff (!RESETN)
        part_taken_r |=> $stable(ACTIVE_PART))
        else $error("Active partition changed after capture.");

    c_row_prog: cover property (@(posedge MCLK) disable iff (!RESETN)
        FL_REQ && FL_CMD.op == flash_seq_pkg::OP_ROW_PROG);
    c_page_erase: cover property (@(posedge MCLK) disable iff (!RESETN)
        FL_REQ && FL_CMD.op == flash_seq_pkg::OP_PAGE_ERASE);
    c_refused: cover property (@(posedge MCLK) disable iff (!RESETN) START_REFUSED);
    c_done: cover property (@(posedge MCLK) disable iff (!RESETN) $fell(BUSY));

endmodule : flash_seq_ctrl

// *** flash_array_model.sv ***
// Behavioural model of the program flash array and of the data RAM behind the sequencer.
// Assumes the sequencer drives its requests from registers on the rising clock edge.
`timescale 1ns/1ps
module flash_array_model (
    input wire logic MCLK, // System clock.
    input wire logic RESETN, // Asynchronous reset, active low.
    input wire logic [15:0] RAM_ADDR, // RAM read address.
    input wire logic RAM_RD, // RAM read strobe.
    output logic [15:0] RAM_RDATA, // RAM read data.
    input wire logic FL_REQ, // Start pulse to the array.
    input wire logic [7:0] DONE_DLY, // Cycles from start to done, at least one.
    output logic FL_DONE // Done pulse from the array.
);
    logic run_r;
    logic [7:0] cnt_r;

    // ==========================================================================
    // RAM and array timing
    // Read data is valid only in the cycle after a read; after that the lines
    // flip every cycle so that stale data reads back inverted one cycle late.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            RAM_RDATA <= 16'h0000;
            FL_DONE <= 1'b0;
            run_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            RAM_RDATA <= RAM_RD ? (RAM_ADDR ^ 16'h5A5A) : ~RAM_RDATA;
            FL_DONE <= 1'b0;
            if (FL_REQ) begin
                run_r <= 1'b1;
                cnt_r <= DONE_DLY;
            end else if (run_r) begin
                if (cnt_r <= 8'h01) begin
                    FL_DONE <= 1'b1;
                    run_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end
        end
    end
endmodule : flash_array_model

// *** program_flash_write_erase_control_tb_top.sv ***
// Self-checking testbench of the flash program and erase sequencer.
// Assumes the sequencer and the array model are compiled before this file.
`timescale 1ns/1ps
module program_flash_write_erase_control_tb_top;
    localparam int N_WORDS = 4;
    typedef struct packed {
        logic [1:0] op;
        logic [23:0] addr;
        logic [15:0] src;
        logic [7:0] dly;
        logic [7:0] words;
    } case_t;
    localparam case_t CASES[5] = '{
        '{2'h0, 24'hA5_0000, 16'h0000, 8'h01, 8'h00},
        '{2'h1, 24'h00_FFFE, 16'h0000, 8'h05, 8'h00},
        '{2'h2, 24'h7F_0100, 16'h0800, 8'h03, 8'h04},
        '{2'h3, 24'hFF_FFFF, 16'h0000, 8'h02, 8'h00},
        '{2'h2, 24'h01_2345, 16'hFFFC, 8'h01, 8'h04}};
    logic MCLK;
    logic RESETN;
    logic [15:0] wdata;
    logic [5:0] we;
    logic strap;
    logic [7:0] dly;
    logic [15:0] ram_rdata;
    logic fl_done;
    flash_seq_pkg::flash_op_t op_sel;
    logic busy;
    logic active_part;
    logic start_refused;
    logic [15:0] ram_addr;
    logic ram_rd;
    logic fl_wstb;
    logic [15:0] fl_wdata;
    flash_seq_pkg::flash_cmd_t fl_cmd;
    logic fl_req;
    int n_errors = 0;
    int n_checks = 0;

    flash_seq_ctrl #(.ROW_WORDS(N_WORDS)) flash_seq_ctrl_i (.MCLK(MCLK), .RESETN(RESETN),
        .WDATA(wdata), .KEY_WE(we[0]), .CTRL_WE(we[1]), .ADDR_HIGH_WE(we[2]),
        .ADDR_LOW_WE(we[3]), .SRC_WE(we[4]), .OTHER_WE(we[5]), .ACTIVE_PART_IN(strap),
        .RAM_RDATA(ram_rdata), .FL_DONE(fl_done), .OP_SEL(op_sel), .BUSY(busy),
        .ACTIVE_PART(active_part), .START_REFUSED(start_refused), .RAM_ADDR(ram_addr),
        .RAM_RD(ram_rd), .FL_WSTB(fl_wstb), .FL_WDATA(fl_wdata), .FL_CMD(fl_cmd),
        .FL_REQ(fl_req));
    flash_array_model flash_array_model_i (.MCLK(MCLK), .RESETN(RESETN), .RAM_ADDR(ram_addr),
        .RAM_RD(ram_rd), .RAM_RDATA(ram_rdata), .FL_REQ(fl_req), .DONE_DLY(dly),
        .FL_DONE(fl_done));

    // ==========================================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Holds one strobe high for one cycle; the caller lowers it or writes again.
    task automatic wr(input int idx, input logic [15:0] d);
        we = 6'(1 << idx);
        wdata = d;
        @(negedge MCLK);
    endtask : wr

    task automatic unlock();
        wr(0, 16'h0055);
        wr(0, 16'h00AA);
    endtask : unlock

    task automatic refuse(input logic exp_busy = 1'b0);
        wr(1, 16'h8001);
        we = '0;
        chk(start_refused, 1'b1);
        chk(busy, exp_busy);
        @(negedge MCLK);
        chk(start_refused, 1'b0);
    endtask : refuse

    task automatic wait_idle();
        for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge MCLK);
        chk(busy, 1'b0);
    endtask : wait_idle

    task automatic run_op(input case_t c);
        int n;
        n = 0;
        dly = c.dly;
        wr(2, {8'h00, c.addr[23:16]});
        wr(3, c.addr[15:0]);
        wr(4, c.src);
        unlock();
        wr(1, {1'b1, 13'h0000, c.op});
        we = '0;
        chk(busy, 1'b1);
        chk({6'h00, fl_cmd}, {6'h00, c.op, c.addr});
        chk(op_sel, c.op);
        for (int k = 0; k < 200 && fl_req !== 1'b1; k++) begin
            if (fl_wstb === 1'b1) begin
                chk(fl_wdata, 16'(c.src + 2 * n) ^ 16'h5A5A);
                n++;
            end
            @(negedge MCLK);
        end
        chk(fl_req, 1'b1);
        chk(n, c.words);
        wait_idle();
    endtask : run_op

    // ==========================================================================
    // Clock, watchdog and test sequence
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end

    initial begin
        #3_000_000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        RESETN = 1'b0;
        wdata = 16'h0000;
        we = '0;
        strap = 1'b1;
        dly = 8'h01;
        repeat (16) @(negedge MCLK);
        RESETN = 1'b1;
        @(negedge MCLK);
        chk({busy, fl_req, ram_rd, fl_wstb, start_refused}, 5'h00);
        chk({6'h00, fl_cmd}, 32'h0000_0000);
        chk(active_part, 1'b1);
        foreach (CASES[i]) run_op(CASES[i]);
        refuse();
        wr(0, 16'h0055);
        wr(5, 16'h0000);
        wr(0, 16'h00AA);
        refuse();
        unlock();
        wr(5, 16'h0000);
        refuse();
        wr(0, 16'h00AA);
        wr(0, 16'h0055);
        refuse();
        wr(0, 16'h0055);
        refuse();
        wr(0, 16'h0033);
        wr(0, 16'h00AA);
        refuse();
        dly = 8'h28;
        unlock();
        wr(1, 16'h8000);
        wr(3, 16'h1234);
        unlock();
        refuse(1'b1);
        wait_idle();
        dly = 8'h01;
        unlock();
        wr(1, 16'h8001);
        we = '0;
        chk(fl_cmd.addr, 24'h01_2345);
        wait_idle();
        unlock();
        wr(1, 16'h8000);
        we = '0;
        strap = 1'b0;
        RESETN = 1'b0;
        @(negedge MCLK);
        chk(busy, 1'b0);
        RESETN = 1'b1;
        @(negedge MCLK);
        chk(active_part, 1'b0);
        refuse();
        tally_and_finish();
    end
endmodule : program_flash_write_erase_control_tb_top
